// >>> common/pcc_consts.vh
// Constants for the counter array capture/compare block.
// Assumes the shared 16-bit counter and its tick source sit outside.
//
// Functional notes
// [R01] Set counter wrap flag on 16-bit rollover.
// [R02] Set cycle wrap flag on bit 8-11 overflow.
// [R03] Flags set regardless of interrupt enables.
// [R04] Interrupt when any flag meets its enable.
// [R05] Processor needs global and array irq enables.
// [R06] Capture on rise, fall or both edges.
// [R07] Capture copies counter, sets channel event flag.
// [R08] Channel flags cleared only by software zero.
// [R09] Timer compare sets flag on 16-bit equality.
// [R10] Low write clears, high write sets comparator.
// [R11] Software writes low byte before high byte.
// [R12] High-speed output toggles pin on match.
// [R13] Comparator off holds pin, skips toggle.
// [R14] Frequency mode: low byte match toggles, adds high.
// [R15] Frequency mode bits; high byte zero means 256.
// [R16] Frequency mode flag on full 16-bit equality.
// [R17] Comparator off: no toggle, PWM drives low.
// [R18] Cycle select gives 8-11 bit; wide gives 16-bit.
// [R19] Shared cycle length; other channels stay independent.
// [R20] Reload view routes compare byte accesses.
// [R21] PWM match sets flag when match enabled.
// [R22] Bit 5 enables cycle wrap interrupt.
// [R23] 8-bit PWM: high on match, low+reload on wrap.
// [R24] 9-11 bit PWM: reload from auto-reload on wrap.
// [R25] 16-bit PWM: high on match, low on wrap.
// [R26] Pin inputs synchronised before edge detection.
// [R27] Flag set wins over same-cycle software clear.
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// =========================================================
// Register selects
`define PCC_SEL_CTRL 3'h0
`define PCC_SEL_MODE 3'h1
`define PCC_SEL_PWM 3'h2
`define PCC_SEL_CPM 3'h3
`define PCC_SEL_CPL 3'h4
`define PCC_SEL_CPH 3'h5

// =========================================================
// Field positions
`define PCC_CTRL_CWF 7
`define PCC_MODE_WIE 0
`define PCC_PWM_RVS 7
`define PCC_PWM_CWIE 5
`define PCC_PWM_CYF 4
`define PCC_PWM_CLS_HI 1
`define PCC_PWM_CLS_LO 0
`define PCC_CPM_WIDE 7
`define PCC_CPM_CEN 6
`define PCC_CPM_RISE 5
`define PCC_CPM_FALL 4
`define PCC_CPM_MFE 3
`define PCC_CPM_TOG 2
`define PCC_CPM_PUL 1
`define PCC_CPM_CIE 0

// =========================================================
// Values
`define PCC_CLS8 2'h0
`define PCC_CLS9 2'h1
`define PCC_CLS10 2'h2
`define PCC_CLS11 2'h3
`define PCC_MASK8 16'h00FF
`define PCC_MASK9 16'h01FF
`define PCC_MASK10 16'h03FF
`define PCC_MASK11 16'h07FF
`define PCC_ZERO16 16'h0000
`define PCC_ZERO8 8'h00

`endif

// >>> design/pcc_sync.v
// Pin synchroniser with edge detection for one module pin.
// Assumes an asynchronous pin; edges count once stages 2 and 3 agree.
`timescale 1ns/1ps
module pcc_sync (
  input wire clk,
  input wire rst_b,
  input wire pin,
  output wire rise,
  output wire fall
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg lvl_r;
  wire agree = (s2_r == s3_r);

  // Glitches shorter than a cycle never reach the level register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
        lvl_r <= s3_r; // [R26]
    end
  end

  assign rise = agree && s3_r && !lvl_r; // [R26]
  assign fall = agree && !s3_r && lvl_r; // [R26]
endmodule // pcc_sync

// >>> design/pcc_match.v
// Counter comparators for one channel: full, low byte and low N bits.
// Assumes the count input is stable in the cycle its tick is high.
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_match (
  input wire tick,
  input wire [15:0] count,
  input wire [15:0] cmp,
  input wire [15:0] mask,
  output wire full,
  output wire low8,
  output wire lown
);
  wire [15:0] diff = count ^ cmp;

  assign full = tick && (diff == `PCC_ZERO16);
  assign low8 = tick && (diff[7:0] == `PCC_ZERO8);
  assign lown = tick && ((diff & mask) == `PCC_ZERO16);
endmodule // pcc_match

// >>> design/pcc_top.v
// Interrupt flags and capture/compare channels on a shared counter.
// Assumes COUNT_TICK pulses once in the cycle after COUNT changed.
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_top #(
  parameter NCH = 3
) (
  input wire CLK,
  input wire RST_B,
  input wire [15:0] COUNT,
  input wire COUNT_TICK,
  input wire WR_EN,
  input wire [2:0] WR_SEL,
  input wire [1:0] WR_CH,
  input wire [7:0] WR_DATA,
  input wire RD_EN,
  input wire [2:0] RD_SEL,
  input wire [1:0] RD_CH,
  output wire [7:0] RD_DATA,
  input wire [NCH-1:0] PIN_IN,
  output wire [NCH-1:0] PIN_OUT,
  output wire [NCH-1:0] PIN_OE_B,
  output wire IRQ
);

  // =========================================================
  // Global configuration and flags
  reg wrap_irq_enable_r;
  reg reload_view_r;
  reg cycle_wrap_irq_enable_r;
  reg [1:0] cycle_length_r;
  reg counter_wrap_flag_r;
  reg cycle_wrap_flag_r;
  reg [NCH-1:0] channel_event_flag_r;
  reg irq_r;
  reg [7:0] rd_data_r;

  reg counter_wrap_flag_nxt;
  reg cycle_wrap_flag_nxt;
  reg [NCH-1:0] channel_event_flag_nxt;

  wire [NCH-1:0] flag_set;
  wire [NCH-1:0] chan_irq_en;
  wire [NCH-1:0] rise_ev;
  wire [NCH-1:0] fall_ev;
  wire [8*NCH-1:0] mode_f;
  wire [16*NCH-1:0] cmp_f;
  wire [16*NCH-1:0] arl_f;

  reg [15:0] len_mask;

  wire wr_ctrl = WR_EN && (WR_SEL == `PCC_SEL_CTRL);
  wire wr_mode = WR_EN && (WR_SEL == `PCC_SEL_MODE);
  wire wr_pwm = WR_EN && (WR_SEL == `PCC_SEL_PWM);

  // =========================================================
  // Overflow detection
  always @* begin
    case (cycle_length_r) // [R02]
      `PCC_CLS8: len_mask = `PCC_MASK8;
      `PCC_CLS9: len_mask = `PCC_MASK9;
      `PCC_CLS10: len_mask = `PCC_MASK10;
      `PCC_CLS11: len_mask = `PCC_MASK11;
      default: len_mask = `PCC_MASK8;
    endcase
  end

  // The tick marks a fresh count, so zero means a rollover just happened
  wire wrap16 = COUNT_TICK && (COUNT == `PCC_ZERO16); // [R01]
  wire cyc_wrap = COUNT_TICK && ((COUNT & len_mask) == `PCC_ZERO16); // [R02]

  // =========================================================
  // Flag next values: a hardware set beats a same-cycle write
  always @* begin
    counter_wrap_flag_nxt = counter_wrap_flag_r;
    cycle_wrap_flag_nxt = cycle_wrap_flag_r;
    channel_event_flag_nxt = channel_event_flag_r;
    if (wr_ctrl) begin
      counter_wrap_flag_nxt = WR_DATA[`PCC_CTRL_CWF];
      channel_event_flag_nxt = WR_DATA[NCH-1:0]; // [R08]
    end
    if (wr_pwm)
      cycle_wrap_flag_nxt = WR_DATA[`PCC_PWM_CYF];
    if (wrap16)
      counter_wrap_flag_nxt = 1'b1; // [R01] [R03] [R27]
    if (cyc_wrap)
      cycle_wrap_flag_nxt = 1'b1; // [R02] [R03] [R27]
    channel_event_flag_nxt = channel_event_flag_nxt | flag_set; // [R03] [R27]
  end

  // =========================================================
  // Global registers
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wrap_irq_enable_r <= 1'b0;
      reload_view_r <= 1'b0;
      cycle_wrap_irq_enable_r <= 1'b0;
      cycle_length_r <= `PCC_CLS8;
      counter_wrap_flag_r <= 1'b0;
      cycle_wrap_flag_r <= 1'b0;
      channel_event_flag_r <= {NCH{1'b0}};
      irq_r <= 1'b0;
    end else begin
      if (wr_mode)
        wrap_irq_enable_r <= WR_DATA[`PCC_MODE_WIE];
      if (wr_pwm) begin
        reload_view_r <= WR_DATA[`PCC_PWM_RVS]; // [R20]
        cycle_wrap_irq_enable_r <= WR_DATA[`PCC_PWM_CWIE]; // [R22]
        cycle_length_r <= WR_DATA[`PCC_PWM_CLS_HI:`PCC_PWM_CLS_LO]; // [R18] [R19]
      end
      counter_wrap_flag_r <= counter_wrap_flag_nxt;
      cycle_wrap_flag_r <= cycle_wrap_flag_nxt;
      channel_event_flag_r <= channel_event_flag_nxt;
      // Registered so the request is glitch free; it trails its flag by one edge
      irq_r <= (counter_wrap_flag_r && wrap_irq_enable_r) ||
               (cycle_wrap_flag_r && cycle_wrap_irq_enable_r) ||
               (|(channel_event_flag_r & chan_irq_en)); // [R04]
    end
  end

  // Masking by the processor's own enables happens outside this block
  assign IRQ = irq_r; // [R05]

  // =========================================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      localparam [1:0] CH = g;

      reg [7:0] mode_r;
      reg [15:0] cmp_r;
      reg [15:0] arl_r;
      reg pin_r;
      reg [7:0] mode_nxt;
      reg [15:0] cmp_nxt;
      reg [15:0] arl_nxt;
      reg pin_nxt;

      wire wr_ch = WR_EN && (WR_CH == CH);
      wire wide = mode_r[`PCC_CPM_WIDE];
      wire cen = mode_r[`PCC_CPM_CEN];
      wire rise = mode_r[`PCC_CPM_RISE];
      wire fall = mode_r[`PCC_CPM_FALL];
      wire mfe = mode_r[`PCC_CPM_MFE];
      wire tog = mode_r[`PCC_CPM_TOG];
      wire pul = mode_r[`PCC_CPM_PUL];

      wire capt_mode = !mfe && !tog && !pul;
      wire pwm_n = pul && !tog && !wide;
      wire pwm16 = pul && !tog && wide;
      wire freq = pul && tog;
      wire m16;
      wire mlo;
      wire mn;

      pcc_sync u_sync (
        .clk (CLK),
        .rst_b (RST_B),
        .pin (PIN_IN[g]),
        .rise (rise_ev[g]),
        .fall (fall_ev[g])
      );

      pcc_match u_match (
        .tick (COUNT_TICK),
        .count (COUNT),
        .cmp (cmp_r),
        .mask (len_mask),
        .full (m16),
        .low8 (mlo),
        .lown (mn)
      );

      wire cap_hit = capt_mode &&
                     ((rise && rise_ev[g]) || (fall && fall_ev[g])); // [R06]

      // 16-bit equality serves timer, toggle, frequency and wide PWM
      wire wide_hit = cen && m16 && (!pul || freq || pwm16); // [R09] [R16] [R21]
      wire narrow_hit = cen && pwm_n && mn; // [R21]

      assign flag_set[g] = cap_hit || (mfe && (wide_hit || narrow_hit)); // [R07] [R09]
      assign chan_irq_en[g] = mode_r[`PCC_CPM_CIE]; // [R04]

      always @* begin
        mode_nxt = mode_r;
        cmp_nxt = cmp_r;
        arl_nxt = arl_r;
        pin_nxt = pin_r;

        if (cap_hit)
          cmp_nxt = COUNT; // [R07]

        // High-speed output; no toggle while the comparator is off
        if (!pul && tog && cen && m16)
          pin_nxt = !pin_r; // [R12] [R13]

        // Adding a zero high byte leaves the low byte: a 256-count half period
        if (freq && cen && mlo) begin
          pin_nxt = !pin_r; // [R14] [R15]
          cmp_nxt[7:0] = cmp_r[7:0] + cmp_r[15:8]; // [R14] [R15]
        end

        if (pwm_n && cen) begin
          if (cyc_wrap) begin
            pin_nxt = 1'b0; // [R23] [R24]
            if (cycle_length_r == `PCC_CLS8)
              cmp_nxt[7:0] = cmp_r[15:8]; // [R23]
            else
              cmp_nxt = arl_r; // [R24]
          end
          // Match after wrap so a zero compare gives full duty
          if (mn)
            pin_nxt = 1'b1; // [R18] [R23] [R24]
        end

        if (pwm16 && cen) begin
          if (wrap16)
            pin_nxt = 1'b0; // [R25]
          if (m16)
            pin_nxt = 1'b1; // [R25]
        end

        if ((pwm_n || pwm16) && !cen)
          pin_nxt = 1'b0; // [R17]

        // Software writes come last and override hardware on the same byte
        if (wr_ch && (WR_SEL == `PCC_SEL_CPM))
          mode_nxt = WR_DATA;
        if (wr_ch && (WR_SEL == `PCC_SEL_CPL)) begin
          mode_nxt[`PCC_CPM_CEN] = 1'b0; // [R10]
          if (reload_view_r)
            arl_nxt[7:0] = WR_DATA; // [R20]
          else
            cmp_nxt[7:0] = WR_DATA; // [R20]
        end
        if (wr_ch && (WR_SEL == `PCC_SEL_CPH)) begin
          mode_nxt[`PCC_CPM_CEN] = 1'b1; // [R10] [R11]
          if (reload_view_r)
            arl_nxt[15:8] = WR_DATA; // [R20]
          else
            cmp_nxt[15:8] = WR_DATA; // [R20]
        end
      end

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          mode_r <= `PCC_ZERO8;
          cmp_r <= `PCC_ZERO16;
          arl_r <= `PCC_ZERO16;
          pin_r <= 1'b0;
        end else begin
          mode_r <= mode_nxt;
          cmp_r <= cmp_nxt;
          arl_r <= arl_nxt;
          pin_r <= pin_nxt;
        end
      end

      assign mode_f[8*g +: 8] = mode_r;
      assign cmp_f[16*g +: 16] = cmp_r;
      assign arl_f[16*g +: 16] = arl_r;
      assign PIN_OUT[g] = pin_r;
      // Capture and timer modes leave the pin to the outside world
      assign PIN_OE_B[g] = !(tog || pul);
    end
  endgenerate

  // =========================================================
  // Read port: data appears on the edge after RD_EN
  reg [7:0] rd_mux;
  wire [15:0] rd_cmp = cmp_f[16*RD_CH +: 16];
  wire [15:0] rd_arl = arl_f[16*RD_CH +: 16];
  wire [15:0] rd_word = reload_view_r ? rd_arl : rd_cmp; // [R20]

  always @* begin
    rd_mux = `PCC_ZERO8;
    case (RD_SEL)
      `PCC_SEL_CTRL: begin
        rd_mux[NCH-1:0] = channel_event_flag_r;
        rd_mux[`PCC_CTRL_CWF] = counter_wrap_flag_r;
      end
      `PCC_SEL_MODE: rd_mux[`PCC_MODE_WIE] = wrap_irq_enable_r;
      `PCC_SEL_PWM: begin
        rd_mux[`PCC_PWM_RVS] = reload_view_r;
        rd_mux[`PCC_PWM_CWIE] = cycle_wrap_irq_enable_r;
        rd_mux[`PCC_PWM_CYF] = cycle_wrap_flag_r;
        rd_mux[`PCC_PWM_CLS_HI:`PCC_PWM_CLS_LO] = cycle_length_r;
      end
      `PCC_SEL_CPM: rd_mux = mode_f[8*RD_CH +: 8];
      `PCC_SEL_CPL: rd_mux = rd_word[7:0];
      `PCC_SEL_CPH: rd_mux = rd_word[15:8];
      default: rd_mux = `PCC_ZERO8;
    endcase
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      rd_data_r <= `PCC_ZERO8;
    else if (RD_EN)
      rd_data_r <= rd_mux;
  end

  assign RD_DATA = rd_data_r;

endmodule // pcc_top

// >>> verification/pcc_top_asserts.sv
// Port checker for the capture/compare block.
// Assumes it sees every register write at the top ports.
`timescale 1ns/1ps
module pcc_top_asserts #(
  parameter NCH = 3
) (
  input wire CLK,
  input wire RST_B,
  input wire [15:0] COUNT,
  input wire COUNT_TICK,
  input wire WR_EN,
  input wire [2:0] WR_SEL,
  input wire [1:0] WR_CH,
  input wire [7:0] WR_DATA,
  input wire RD_EN,
  input wire [2:0] RD_SEL,
  input wire [1:0] RD_CH,
  input wire [7:0] RD_DATA,
  input wire [NCH-1:0] PIN_IN,
  input wire [NCH-1:0] PIN_OUT,
  input wire [NCH-1:0] PIN_OE_B,
  input wire IRQ
);
  // =========================================================
  // Shadow of the mode and enable bits, kept from the write port
  reg [7:0] m_r [0:2];
  reg wie_r;
  reg cwie_r;
  integer k;
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (k = 0; k < 3; k = k + 1) m_r[k] <= 8'h00;
      wie_r <= 1'b0;
      cwie_r <= 1'b0;
    end else if (WR_EN && WR_CH != 2'h3) begin
      if (WR_SEL == 3'h3) m_r[WR_CH] <= WR_DATA;
      if (WR_SEL == 3'h4) m_r[WR_CH][6] <= 1'b0;
      if (WR_SEL == 3'h5) m_r[WR_CH][6] <= 1'b1;
      if (WR_SEL == 3'h1) wie_r <= WR_DATA[0];
      if (WR_SEL == 3'h2) cwie_r <= WR_DATA[5];
    end
  end
  wire [2:0] drv = {m_r[2][2] | m_r[2][1], m_r[1][2] | m_r[1][1], m_r[0][2] | m_r[0][1]};
  wire quiet = !(wie_r || cwie_r || m_r[0][0] || m_r[1][0] || m_r[2][0]);
  // Frequency mode holds its pin with the comparator off, so only PWM is forced low
  wire off0 = m_r[0][1] && !m_r[0][2] && !m_r[0][6];
  wire hso_off0 = m_r[0][2] && !m_r[0][1] && !m_r[0][6];
  sequence s_off0;
    off0 ##1 off0;
  endsequence
  sequence s_quiet;
    quiet ##1 quiet;
  endsequence

  // =========================================================
  // Assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  pin_dir_a: assert property (PIN_OE_B == ~drv[NCH-1:0])
    else $error("pin enable does not follow mode");
  // A mode write acts on the pin one cycle late, so the cycle after a write is exempt
  hold_idle_a: assert property (!COUNT_TICK && !WR_EN && !$past(WR_EN) |=> $stable(PIN_OUT))
    else $error("pin moved without a tick");
  hso_hold_a: assert property (hso_off0 && !WR_EN |=> $stable(PIN_OUT[0]))
    else $error("pin toggled with comparator off");
  pwm_off_a: assert property (s_off0 |-> !PIN_OUT[0])
    else $error("pulse output high with comparator off");
  irq_quiet_a: assert property (s_quiet |-> !IRQ)
    else $error("irq with all enables clear");
  rise_tick_a: assert property ($rose(PIN_OUT[0]) |-> $past(COUNT_TICK))
    else $error("pin rose without a tick");
  rd_hold_a: assert property (!RD_EN |=> $stable(RD_DATA))
    else $error("read data changed without a read");
  unmapped_a: assert property (RD_EN && RD_SEL > 3'h5 |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // pcc_top_asserts

bind pcc_top pcc_top_asserts #(.NCH(NCH)) i_pcc_top_asserts (.CLK(CLK), .RST_B(RST_B),
  .COUNT(COUNT), .COUNT_TICK(COUNT_TICK), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .WR_CH(WR_CH),
  .WR_DATA(WR_DATA), .RD_EN(RD_EN), .RD_SEL(RD_SEL), .RD_CH(RD_CH), .RD_DATA(RD_DATA),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_B(PIN_OE_B), .IRQ(IRQ));

// >>> verification/pcc_pins.sv
// External circuitry on the three module pins.
// Assumes the bench sets the level it wants where the block does not drive.
`timescale 1ns/1ps
module pcc_pins (
  input wire [2:0] pin_out,
  input wire [2:0] pin_oe_b,
  input wire [2:0] ext_lvl,
  output wire [2:0] pin_in
);
  // The wire follows the block where it drives, else the outside level
  assign pin_in = (~pin_oe_b & pin_out) | (pin_oe_b & ext_lvl);
endmodule // pcc_pins

// >>> verification/pcc_top_bench.sv
// Self-checking bench for the capture/compare block.
// Assumes the counter is modelled here and ticks only on request.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module pcc_top_bench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [15:0] count = 16'h0000;
  reg count_tick = 1'b0;
  reg wr_en = 1'b0;
  reg [2:0] wr_sel = 3'h0;
  reg [1:0] wr_ch = 2'h0;
  reg [7:0] wr_data = 8'h00;
  reg rd_en = 1'b0;
  reg [2:0] rd_sel = 3'h0;
  reg [1:0] rd_ch = 2'h0;
  reg [2:0] ext = 3'h0;
  reg [7:0] md;
  wire [7:0] rd_data;
  wire [2:0] pin_in, pin_out, pin_oe_b;
  wire irq;
  integer bad_count = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i;
  always #2.5 clk = ~clk;
  pcc_top #(.NCH(3)) i_pcc_top (.CLK(clk), .RST_B(rst_b), .COUNT(count),
    .COUNT_TICK(count_tick), .WR_EN(wr_en), .WR_SEL(wr_sel), .WR_CH(wr_ch),
    .WR_DATA(wr_data), .RD_EN(rd_en), .RD_SEL(rd_sel), .RD_CH(rd_ch), .RD_DATA(rd_data),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_B(pin_oe_b), .IRQ(irq));
  pcc_pins i_pcc_pins (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext_lvl(ext), .pin_in(pin_in));

  // =========================================================
  // Port tasks
  task wr(input [2:0] s, input [1:0] c, input [7:0] d);
    begin
      @(posedge clk); #1;
      wr_en = 1'b1; wr_sel = s; wr_ch = c; wr_data = d;
      @(posedge clk); #1;
      wr_en = 1'b0;
    end
  endtask
  task rd(input [2:0] s, input [1:0] c);
    begin
      @(posedge clk); #1;
      rd_en = 1'b1; rd_sel = s; rd_ch = c;
      @(posedge clk); #1;
      rd_en = 1'b0;
    end
  endtask
  task tk(input [15:0] c);
    begin
      @(posedge clk); #1;
      count = c;
      @(posedge clk); #1;
      count_tick = 1'b1;
      @(posedge clk); #1;
      count_tick = 1'b0;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // =========================================================
  // Scenarios
  task t_wrap;
    begin
      `CHK("oe idle", 3'h7, pin_oe_b)
      for (i = 0; i < 8; i = i + 1) begin
        rd(i[2:0], 2'h0);
        `CHK("reset reg", 8'h00, rd_data)
      end
      tk(16'h0000);
      rd(3'h0, 2'h0);
      `CHK("wrap flag", 8'h80, rd_data)
      `CHK("irq masked", 1'b0, irq)
      for (i = 0; i < 4; i = i + 1) begin
        wr(3'h2, 2'h0, i[7:0]);
        tk(16'h0080 << i);
        rd(3'h2, 2'h0);
        `CHK("cycle early", i[7:0], rd_data)
        tk(16'h0100 << i);
        rd(3'h2, 2'h0);
        `CHK("cycle flag", 8'h10 | i[7:0], rd_data)
      end
      wr(3'h2, 2'h0, 8'h23);
      tk(16'h0800);
      rd(3'h2, 2'h0);
      `CHK("cycle irq", 1'b1, irq)
      wr(3'h2, 2'h0, 8'h00);
      wr(3'h1, 2'h0, 8'h01);
      rd(3'h0, 2'h0);
      `CHK("wrap irq", 1'b1, irq)
      wr(3'h0, 2'h0, 8'h00);
      wr(3'h1, 2'h0, 8'h00);
      rd(3'h0, 2'h0);
      `CHK("flag clear", 8'h00, rd_data)
      `CHK("irq drop", 1'b0, irq)
      $display("wrap test done");
    end
  endtask
  task t_capture;
    begin
      count = 16'hA5C3;
      for (i = 0; i < 3; i = i + 1) begin
        md = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30;
        wr(3'h3, 2'h1, md);
        wr(3'h0, 2'h0, 8'h00);
        ext[1] = 1'b1;
        repeat (6) @(posedge clk);
        rd(3'h0, 2'h0);
        `CHK("rise cap", {6'h00, md[5], 1'b0}, rd_data)
        wr(3'h0, 2'h0, 8'h00);
        ext[1] = 1'b0;
        repeat (6) @(posedge clk);
        rd(3'h0, 2'h0);
        `CHK("fall cap", {6'h00, md[4], 1'b0}, rd_data)
      end
      rd(3'h4, 2'h1);
      `CHK("cap low", 8'hC3, rd_data)
      rd(3'h5, 2'h1);
      `CHK("cap high", 8'hA5, rd_data)
      wr(3'h3, 2'h1, 8'h00);
      wr(3'h0, 2'h0, 8'h00);
      $display("capture test done");
    end
  endtask
  task t_out;
    begin
      wr(3'h4, 2'h0, 8'h10);
      wr(3'h5, 2'h0, 8'h00);
      wr(3'h3, 2'h0, 8'h4D);
      tk(16'h0010);
      `CHK("hso pin", 1'b1, pin_out[0])
      rd(3'h0, 2'h0);
      `CHK("hso flag", 8'h01, rd_data)
      `CHK("hso irq", 1'b1, irq)
      wr(3'h4, 2'h0, 8'h10);
      rd(3'h3, 2'h0);
      `CHK("low clears", 8'h0D, rd_data)
      tk(16'h0010);
      `CHK("hso held", 1'b1, pin_out[0])
      wr(3'h5, 2'h0, 8'h00);
      rd(3'h3, 2'h0);
      `CHK("high sets", 8'h4D, rd_data)
      tk(16'h0010);
      `CHK("hso back", 1'b0, pin_out[0])
      wr(3'h0, 2'h0, 8'h00);
      wr(3'h4, 2'h0, 8'h05);
      wr(3'h5, 2'h0, 8'h03);
      wr(3'h3, 2'h0, 8'h46);
      tk(16'h1205);
      `CHK("freq pin", 1'b1, pin_out[0])
      rd(3'h4, 2'h0);
      `CHK("freq add", 8'h08, rd_data)
      rd(3'h0, 2'h0);
      `CHK("freq noflag", 8'h00, rd_data)
      wr(3'h3, 2'h0, 8'h00);
      $display("output test done");
    end
  endtask
  task t_pwm;
    begin
      wr(3'h2, 2'h0, 8'h00);
      wr(3'h4, 2'h2, 8'h80);
      wr(3'h5, 2'h2, 8'h40);
      wr(3'h3, 2'h2, 8'h4A);
      tk(16'h0080);
      `CHK("pwm high", 1'b1, pin_out[2])
      rd(3'h0, 2'h0);
      `CHK("pwm flag", 8'h04, rd_data)
      tk(16'h0100);
      `CHK("pwm low", 1'b0, pin_out[2])
      rd(3'h4, 2'h2);
      `CHK("pwm reload", 8'h40, rd_data)
      wr(3'h4, 2'h1, 8'h34);
      wr(3'h5, 2'h1, 8'h12);
      wr(3'h3, 2'h1, 8'hCA);
      tk(16'h1234);
      `CHK("p16 high", 1'b1, pin_out[1])
      wr(3'h4, 2'h2, 8'h40);
      tk(16'h0000);
      `CHK("p16 wrap", 2'h0, pin_out[2:1])
      $display("pwm test done");
    end
  endtask

  // =========================================================
  // Main sequence and hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_wrap;
    t_capture;
    t_out;
    t_pwm;
    finish_test;
  end
endmodule // pcc_top_bench
